// *** design/ssu_pkg.sv ***
// package: register map, fields, reset values and sync states of the link setup block
package ssu_pkg;
   // ----------------------------------------------------------------
   // register offsets (byte addresses on the 12-bit register port)
   // ----------------------------------------------------------------
   localparam logic [11:0] ADDR_SYNC_CTRL = 12'h03A;
   localparam logic [11:0] ADDR_SYNC_STAT = 12'h03B;
   localparam logic [11:0] ADDR_LINK_CTRL = 12'h300;
   localparam logic [11:0] ADDR_SUBCLASS = 12'h301;
   localparam logic [11:0] ADDR_MF_DELAY_LO = 12'h304;
   localparam logic [11:0] ADDR_MF_DELAY_HI = 12'h305;
   localparam logic [11:0] ADDR_WINDOW_LO = 12'h306;
   localparam logic [11:0] ADDR_WINDOW_HI = 12'h307;
   localparam logic [11:0] ADDR_XBAR_BASE = 12'h308;
   localparam logic [11:0] ADDR_XBAR_LAST = 12'h30B;
   localparam logic [11:0] ADDR_POLARITY = 12'h334;
   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int CTRL_ENABLE_BIT = 7;
   localparam int CTRL_ARM_BIT = 6;
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_MODE_W = 4;
   localparam logic [3:0] MODE_ONE_SHOT = 4'h1;
   localparam int STAT_WAIT_BIT = 0;
   localparam int STAT_ENABLE_BIT = 1;
   localparam int STAT_LOCK_BIT = 3;
   localparam int LINK_SUM_BIT = 6;
   localparam int LINK_TWO_BIT = 3;
   localparam int LINK_PAGE_BIT = 2;
   localparam int LINK_EN_LSB = 0;
   localparam int SUBCLASS_BIT = 0;
   localparam int XBAR_SEL_W = 3;
   // ----------------------------------------------------------------
   // sizes, reset values, timing
   // ----------------------------------------------------------------
   localparam int LANES = 8;
   localparam int LANE_W = 8;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [4:0] LMFC_LAST = 5'h1F;
   // ----------------------------------------------------------------
   // sync machine states, one-hot
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      SSU_IDLE = 4'b0001,
      SSU_ENABLED = 4'b0010,
      SSU_ARMED = 4'b0100,
      SSU_LOCKED = 4'b1000
   } ssu_sync_state_type;
endpackage

// *** design/ssu_sysref_edge.sv ***
// sysref rising edge detector
`timescale 1ns/100ps
module ssu_sysref_edge
   import ssu_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic sysref,
   output logic sysref_edge
);
   // ----------------------------------------------------------------
   // edge detect
   // ----------------------------------------------------------------
   logic sysref_prev; // last sampled level

   // sysref is taken as synchronous, so no synchroniser sits here
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         sysref_prev <= 1'b0;
      end else begin
         sysref_prev <= sysref;
      end
   end

   // a level held high through reset reads as an edge until the first clock after reset
   assign sysref_edge = sysref & ~sysref_prev;
endmodule

// *** design/ssu_lane_crossbar.sv ***
// lane crossbar: physical to logical lane routing with polarity inversion
`timescale 1ns/100ps
module ssu_lane_crossbar
   import ssu_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [LANES*LANE_W-1:0] phys_lanes,
   input wire logic [LANES*XBAR_SEL_W-1:0] lane_select,
   input wire logic [LANES-1:0] polarity_mask,
   output logic [LANES*LANE_W-1:0] logical_lanes
);
   // ----------------------------------------------------------------
   // one mux per logical lane
   // ----------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < LANES; g++) begin : g_lane
         logic [XBAR_SEL_W-1:0] sel; // physical source of this lane
         assign sel = lane_select[g*XBAR_SEL_W +: XBAR_SEL_W];
         // registered so the lane word leaves from a flip-flop
         always_ff @(posedge clk) begin
            if (!rst_n) begin
               logical_lanes[g*LANE_W +: LANE_W] <= RESET_BYTE;
            end else begin
               logical_lanes[g*LANE_W +: LANE_W] <= phys_lanes[sel*LANE_W +: LANE_W]
                  ^ {LANE_W{polarity_mask[g]}}; // [R6]
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   property p_lane0_route;
      @(posedge clk) disable iff (!rst_n)
      ##1 logical_lanes[LANE_W-1:0] == (LANE_W'($past(phys_lanes) >> ($past(lane_select[XBAR_SEL_W-1:0]) * LANE_W))
         ^ {LANE_W{$past(polarity_mask[0])}});
   endproperty
   a_lane0_route: assert property (p_lane0_route) else $error("lane 0 misrouted"); // [R6]
endmodule

// *** design/ssu_link_setup.sv ***
// link setup top: register file, lmfc sync machine, latency, crossbar and link enables
//
// Notes on behaviour
// R1: host selects one-shot mode, then enables machine
// R2: writing arm makes device wait for alignment
// R3: far end sends sysref after arming
// R4: sysref edge sets lock bit three
// R5: multiframe delay and window in register pairs
// R6: crossbar registers route physical to logical lanes
// R7: link enable field, dual enables both
// R8: host writes per-link setup per page
// R9: subclass picks deterministic, sysref-aligned latency
// R10: lock stays clear from arming until aligned
//
// Our own choice: the strobed register port.
`timescale 1ns/100ps
module ssu_link_setup
   import ssu_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [11:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [7:0] reg_rdata,
   input wire logic sysref,
   input wire logic [LANES*LANE_W-1:0] phys_lane_data,
   output logic [LANES*LANE_W-1:0] logical_lane_data,
   output logic [1:0] link_enable,
   output logic two_link_select,
   output logic link_page_select,
   output logic config_sum_select,
   output logic deterministic_latency,
   output logic [15:0] multiframe_delay,
   output logic [15:0] delay_window,
   output logic lmfc_pulse,
   output logic lmfc_locked
);
   // ----------------------------------------------------------------
   // register storage
   // ----------------------------------------------------------------
   logic [7:0] sync_machine_control; // mode, enable, arm
   logic [7:0] link_control; // sum select, two link, page, enables
   logic [7:0] latency_subclass_select; // bit 0 picks subclass 1
   logic [7:0] multiframe_delay_low; // delay low byte
   logic [7:0] multiframe_delay_high; // delay high byte
   logic [7:0] delay_window_low; // window low byte
   logic [7:0] delay_window_high; // window high byte
   logic [7:0] lane_crossbar [0:3]; // two lane selects per byte
   logic [7:0] lane_polarity_invert; // one bit per logical lane

   // ----------------------------------------------------------------
   // sync machine signals
   // ----------------------------------------------------------------
   ssu_sync_state_type sync_state; // current state
   ssu_sync_state_type next_sync_state; // next state
   logic sysref_edge; // rising edge of sysref
   logic lock_event; // alignment taken this cycle
   logic realign; // lmfc phase restarts this cycle
   logic [4:0] lmfc_count; // local multiframe phase
   logic [4:0] next_lmfc_count; // next phase
   logic ctrl_write; // write to sync control
   logic [7:0] sync_machine_status; // read view of the machine
   logic [LANES*XBAR_SEL_W-1:0] lane_select; // flattened crossbar

   assign ctrl_write = reg_write && (reg_addr == ADDR_SYNC_CTRL);

   // ----------------------------------------------------------------
   // sysref edge detector
   // ----------------------------------------------------------------
   ssu_sysref_edge u_edge (
      .clk(clk),
      .rst_n(rst_n),
      .sysref(sysref),
      .sysref_edge(sysref_edge)
   );

   // ----------------------------------------------------------------
   // sync machine next state
   // ----------------------------------------------------------------
   // a control write always wins over the machine's own progress,
   // so a rearm in the lock cycle is never lost
   always_comb begin
      next_sync_state = sync_state;
      lock_event = 1'b0;
      realign = 1'b0;
      case (sync_state)
         SSU_IDLE: begin
            // waiting for the host to enable
            next_sync_state = SSU_IDLE;
         end
         SSU_ENABLED: begin
            // enabled, not armed
            next_sync_state = SSU_ENABLED;
         end
         SSU_ARMED: begin
            if (!latency_subclass_select[SUBCLASS_BIT]) begin
               // subclass 0: no external alignment, lock at once
               lock_event = 1'b1; // [R9]
               next_sync_state = SSU_LOCKED;
            end else if (sysref_edge) begin
               // relies on the far end sending an edge once armed [R3]
               lock_event = 1'b1; // [R4]
               realign = 1'b1; // [R9]
               next_sync_state = SSU_LOCKED;
            end else begin
               // keep waiting, lock stays clear [R10]
               next_sync_state = SSU_ARMED;
            end
         end
         SSU_LOCKED: begin
            // holds until software rewrites control
            next_sync_state = SSU_LOCKED;
         end
         default: begin
            next_sync_state = SSU_IDLE;
         end
      endcase
      if (ctrl_write) begin
         lock_event = 1'b0;
         realign = 1'b0;
         if (!reg_wdata[CTRL_ENABLE_BIT]) begin
            // mode select alone leaves the machine off [R1]
            next_sync_state = SSU_IDLE;
         end else if (reg_wdata[CTRL_ARM_BIT]
                      && reg_wdata[CTRL_MODE_LSB +: CTRL_MODE_W] == MODE_ONE_SHOT) begin
            // arm: wait for alignment [R2]
            next_sync_state = SSU_ARMED;
         end else begin
            // enable without arm, or an unsupported mode [R1]
            next_sync_state = SSU_ENABLED;
         end
      end
   end

   // ----------------------------------------------------------------
   // sync machine state register
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         sync_state <= SSU_IDLE;
      end else begin
         sync_state <= next_sync_state;
      end
   end

   // ----------------------------------------------------------------
   // sync control register
   // ----------------------------------------------------------------
   // the arm bit drops by itself once locked, one-shot style;
   // a host write in the same cycle overrides that clear
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         sync_machine_control <= RESET_BYTE;
      end else if (ctrl_write) begin
         sync_machine_control <= reg_wdata; // [R2]
      end else if (lock_event) begin
         sync_machine_control[CTRL_ARM_BIT] <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // lock flag
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         lmfc_locked <= 1'b0;
      end else begin
         // set only by alignment, cleared on any arm or disable
         lmfc_locked <= (next_sync_state == SSU_LOCKED); // [R4] [R10]
      end
   end

   // ----------------------------------------------------------------
   // local multiframe clock
   // ----------------------------------------------------------------
   // free running; a sysref edge in the armed state with subclass 1 selected restarts the phase
   always_comb begin
      if (realign) begin
         next_lmfc_count = 5'h00; // [R9]
      end else if (lmfc_count == LMFC_LAST) begin
         next_lmfc_count = 5'h00;
      end else begin
         next_lmfc_count = lmfc_count + 5'h01;
      end
   end

   // phase counter and boundary pulse
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         lmfc_count <= 5'h00;
         lmfc_pulse <= 1'b0;
      end else begin
         lmfc_count <= next_lmfc_count;
         lmfc_pulse <= (next_lmfc_count == 5'h00);
      end
   end

   // ----------------------------------------------------------------
   // link and subclass registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         link_control <= RESET_BYTE;
         latency_subclass_select <= RESET_BYTE;
      end else if (reg_write) begin
         if (reg_addr == ADDR_LINK_CTRL) begin
            link_control <= reg_wdata; // [R7]
         end
         if (reg_addr == ADDR_SUBCLASS) begin
            latency_subclass_select <= reg_wdata; // [R9]
         end
      end
   end

   // ----------------------------------------------------------------
   // latency registers
   // ----------------------------------------------------------------
   // the page bit is only passed out; per-link copies live downstream
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         multiframe_delay_low <= RESET_BYTE;
         multiframe_delay_high <= RESET_BYTE;
         delay_window_low <= RESET_BYTE;
         delay_window_high <= RESET_BYTE;
      end else if (reg_write) begin
         case (reg_addr)
            ADDR_MF_DELAY_LO: begin
               multiframe_delay_low <= reg_wdata; // [R5]
            end
            ADDR_MF_DELAY_HI: begin
               multiframe_delay_high <= reg_wdata; // [R5]
            end
            ADDR_WINDOW_LO: begin
               delay_window_low <= reg_wdata; // [R5]
            end
            ADDR_WINDOW_HI: begin
               delay_window_high <= reg_wdata; // [R5]
            end
            default: begin
               // other addresses leave latency alone
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // crossbar and polarity registers
   // ----------------------------------------------------------------
   // reset maps each logical lane onto the same physical lane
   genvar x;
   generate
      for (x = 0; x < 4; x++) begin : g_xbar
         always_ff @(posedge clk) begin
            if (!rst_n) begin
               lane_crossbar[x] <= {2'b00, 3'(2 * x + 1), 3'(2 * x)};
            end else if (reg_write && reg_addr == ADDR_XBAR_BASE + 12'(x)) begin
               lane_crossbar[x] <= reg_wdata; // [R6]
            end
         end
         assign lane_select[x*6 +: 6] = lane_crossbar[x][5:0];
      end
   endgenerate

   // polarity mask register
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         lane_polarity_invert <= RESET_BYTE;
      end else if (reg_write && reg_addr == ADDR_POLARITY) begin
         lane_polarity_invert <= reg_wdata;
      end
   end

   // ----------------------------------------------------------------
   // lane crossbar datapath
   // ----------------------------------------------------------------
   ssu_lane_crossbar u_xbar (
      .clk(clk),
      .rst_n(rst_n),
      .phys_lanes(phys_lane_data),
      .lane_select(lane_select),
      .polarity_mask(lane_polarity_invert),
      .logical_lanes(logical_lane_data)
   );

   // ----------------------------------------------------------------
   // outputs from the registers
   // ----------------------------------------------------------------
   // in single link mode link 1 is forced off whatever is written
   assign link_enable = two_link_select ? link_control[LINK_EN_LSB +: 2]
                        : {1'b0, link_control[LINK_EN_LSB]}; // [R7]
   assign two_link_select = link_control[LINK_TWO_BIT];
   assign link_page_select = link_control[LINK_PAGE_BIT];
   assign config_sum_select = link_control[LINK_SUM_BIT];
   assign deterministic_latency = latency_subclass_select[SUBCLASS_BIT]; // [R9]
   assign multiframe_delay = {multiframe_delay_high, multiframe_delay_low};
   assign delay_window = {delay_window_high, delay_window_low};

   // ----------------------------------------------------------------
   // status view
   // ----------------------------------------------------------------
   always_comb begin
      sync_machine_status = RESET_BYTE;
      sync_machine_status[STAT_LOCK_BIT] = lmfc_locked; // [R4]
      sync_machine_status[STAT_ENABLE_BIT] = (sync_state != SSU_IDLE);
      sync_machine_status[STAT_WAIT_BIT] = (sync_state == SSU_ARMED);
   end

   // ----------------------------------------------------------------
   // read port
   // ----------------------------------------------------------------
   // data stands for exactly the cycle after the strobe, zero elsewhere;
   // unmapped addresses read as zero
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         reg_rdata <= RESET_BYTE;
      end else if (!reg_read) begin
         reg_rdata <= RESET_BYTE;
      end else begin
         case (reg_addr)
            ADDR_SYNC_CTRL: reg_rdata <= sync_machine_control;
            ADDR_SYNC_STAT: reg_rdata <= sync_machine_status; // [R4]
            ADDR_LINK_CTRL: reg_rdata <= link_control;
            ADDR_SUBCLASS: reg_rdata <= latency_subclass_select;
            ADDR_MF_DELAY_LO: reg_rdata <= multiframe_delay_low;
            ADDR_MF_DELAY_HI: reg_rdata <= multiframe_delay_high;
            ADDR_WINDOW_LO: reg_rdata <= delay_window_low;
            ADDR_WINDOW_HI: reg_rdata <= delay_window_high;
            ADDR_XBAR_BASE: reg_rdata <= lane_crossbar[0];
            ADDR_XBAR_BASE + 12'h001: reg_rdata <= lane_crossbar[1];
            ADDR_XBAR_BASE + 12'h002: reg_rdata <= lane_crossbar[2];
            ADDR_XBAR_LAST: reg_rdata <= lane_crossbar[3];
            ADDR_POLARITY: reg_rdata <= lane_polarity_invert;
            default: reg_rdata <= RESET_BYTE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   property p_arm_waits;
      ctrl_write && reg_wdata == 8'hC1 |=> sync_state == SSU_ARMED && !lmfc_locked;
   endproperty
   a_arm_waits: assert property (p_arm_waits) else $error("arm did not start wait"); // [R2]

   property p_lock_on_edge;
      sync_state == SSU_ARMED && deterministic_latency && sysref_edge && !ctrl_write
         |=> lmfc_locked && lmfc_count == 5'h00 && !sync_machine_control[CTRL_ARM_BIT];
   endproperty
   a_lock_on_edge: assert property (p_lock_on_edge) else $error("no lock after sysref"); // [R4]

   property p_clear_while_armed;
      sync_state == SSU_ARMED |-> !lmfc_locked;
   endproperty
   a_clear_while_armed: assert property (p_clear_while_armed) else $error("lock set while armed"); // [R10]

   property p_no_edge_no_lock;
      sync_state == SSU_ARMED && deterministic_latency && !sysref_edge && !ctrl_write |=> !lmfc_locked;
   endproperty
   a_no_edge_no_lock: assert property (p_no_edge_no_lock) else $error("lock without sysref"); // [R10]

   property p_subclass0_lock;
      sync_state == SSU_ARMED && !deterministic_latency && !ctrl_write |=> lmfc_locked;
   endproperty
   a_subclass0_lock: assert property (p_subclass0_lock) else $error("subclass 0 did not lock"); // [R9]

   property p_single_link;
      !two_link_select |-> !link_enable[1] && link_enable[0] == link_control[0];
   endproperty
   a_single_link: assert property (p_single_link) else $error("link 1 on in single mode"); // [R7]

   property p_dual_link;
      reg_write && reg_addr == ADDR_LINK_CTRL && reg_wdata[3] && reg_wdata[1:0] == 2'h3 |=> link_enable == 2'h3;
   endproperty
   a_dual_link: assert property (p_dual_link) else $error("dual link not enabled"); // [R7]

   property p_delay_write;
      reg_write && reg_addr == ADDR_MF_DELAY_HI |=> multiframe_delay[15:8] == $past(reg_wdata);
   endproperty
   a_delay_write: assert property (p_delay_write) else $error("delay high byte lost"); // [R5]

   property p_status_read;
      reg_read && reg_addr == ADDR_SYNC_STAT |=> reg_rdata[3] == $past(lmfc_locked) ##1 reg_rdata == 8'h00 || $past(reg_read);
   endproperty
   a_status_read: assert property (p_status_read) else $error("status read wrong"); // [R4]

   c_lock_sysref: cover property (sync_state == SSU_ARMED && sysref_edge ##1 lmfc_locked);
   c_single_link: cover property (!two_link_select && link_enable == 2'h1);
   c_dual_link: cover property (two_link_select && link_enable == 2'h3);
   c_rearm: cover property (lmfc_locked ##1 sync_state == SSU_ARMED);
endmodule

// *** verif/ssu_tx_model.sv ***
// partner model: transmitter side driving sysref and lane bytes
`timescale 1ns/100ps
module ssu_tx_model
   import ssu_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic fire,
   output logic sysref,
   output logic [LANES*LANE_W-1:0] lanes
);
   logic [3:0] cnt; // moves every cycle so stale lane data shows
   logic [2:0] hold; // cycles of sysref high left
   // ----------------------------------------------------------------
   // sysref pulse on each fire request, whatever the arm state
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cnt <= 4'h0;
         hold <= 3'h0;
         sysref <= 1'b0;
      end else begin
         cnt <= cnt + 4'h1;
         sysref <= (hold != 3'h0);
         if (fire) begin
            hold <= 3'h4;
         end else if (hold != 3'h0) begin
            hold <= hold - 3'h1;
         end
      end
   end
   // lane n carries its number in the high nibble
   always_comb begin
      for (int n = 0; n < LANES; n++) begin
         lanes[8*n +: 8] = {4'(n), cnt};
      end
   end
endmodule

// *** verif/tb_top.sv ***
// testbench: register port, sync machine, latency, crossbar and link enables
`timescale 1ns/100ps
module tb_top
   import ssu_pkg::*;
;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [11:0] reg_addr = 12'h000;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_write = 1'b0;
   logic reg_read = 1'b0;
   logic fire = 1'b0;
   logic [7:0] reg_rdata, d;
   logic sysref, two, page, sum, det, pulse, locked;
   logic [63:0] phys, logic_out, p;
   logic [1:0] link_en;
   logic [15:0] mfd, dw;
   int fail_count = 0;
   int checks_done = 0;
   always #4 clk = ~clk;
   ssu_tx_model tx (.clk(clk), .rst_n(rst_n), .fire(fire), .sysref(sysref), .lanes(phys));
   ssu_link_setup uut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .sysref(sysref),
      .phys_lane_data(phys), .logical_lane_data(logic_out), .link_enable(link_en),
      .two_link_select(two), .link_page_select(page), .config_sum_select(sum),
      .deterministic_latency(det), .multiframe_delay(mfd), .delay_window(dw),
      .lmfc_pulse(pulse), .lmfc_locked(locked));
   // ----------------------------------------------------------------
   // shared bus cycles and comparison
   // ----------------------------------------------------------------
   task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
      checks_done++;
      if (s !== e) begin
         fail_count++;
         $display("unexpected %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] v);
      @(posedge clk);
      reg_write <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge clk);
      reg_write <= 1'b0;
   endtask
   // read data stands only in the cycle after the strobe
   task automatic rd(input logic [11:0] a, output logic [7:0] v);
      @(posedge clk);
      reg_read <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_read <= 1'b0;
      #1 v = reg_rdata;
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_reset();
      rd(ADDR_XBAR_BASE, d); chk("xbar0", 16'(d), 16'h0008);
      rd(ADDR_XBAR_LAST, d); chk("xbar3", 16'(d), 16'h003E);
      rd(ADDR_SYNC_CTRL, d); chk("ctrl", 16'(d), 16'h0000);
      rd(12'h123, d); chk("unmapped", 16'(d), 16'h0000);
      $display("reset test done");
   endtask
   task automatic t_sync();
      wr(ADDR_SUBCLASS, 8'h01);
      #1 chk("det", 16'(det), 16'h0001);
      wr(ADDR_SYNC_CTRL, 8'h01);
      wr(ADDR_SYNC_CTRL, 8'h81);
      wr(ADDR_SYNC_CTRL, 8'hC1);
      rd(ADDR_SYNC_STAT, d); chk("armed", 16'(d), 16'h0003);
      repeat (5) @(posedge clk);
      #1 chk("no lock", 16'(locked), 16'h0000);
      @(posedge clk) fire <= 1'b1;
      @(posedge clk) fire <= 1'b0;
      // the model raises sysref two edges after fire, lock follows one edge later
      repeat (2) @(posedge clk);
      #1 chk("lock", 16'(locked), 16'h0001);
      chk("lmfc pulse", 16'(pulse), 16'h0001);
      @(posedge clk);
      #1 chk("lmfc idle", 16'(pulse), 16'h0000);
      rd(ADDR_SYNC_STAT, d); chk("stat", 16'(d), 16'h000A);
      rd(ADDR_SYNC_CTRL, d); chk("ctrl", 16'(d), 16'h0081);
      // subclass 0 rearm: lock drops at arming, then returns without sysref
      wr(ADDR_SUBCLASS, 8'h00);
      wr(ADDR_SYNC_CTRL, 8'hC1);
      #1 chk("rearm", 16'(locked), 16'h0000);
      rd(ADDR_SYNC_STAT, d); chk("sub0 lock", 16'(d), 16'h000A);
      // arm with a mode other than one shot only enables
      wr(ADDR_SYNC_CTRL, 8'hC2);
      rd(ADDR_SYNC_STAT, d); chk("bad mode", 16'(d), 16'h0002);
      $display("sync test done");
   endtask
   task automatic t_lat();
      wr(ADDR_MF_DELAY_LO, 8'h34);
      wr(ADDR_MF_DELAY_HI, 8'h12);
      wr(ADDR_WINDOW_LO, 8'h78);
      wr(ADDR_WINDOW_HI, 8'h56);
      #1 chk("mfd", mfd, 16'h1234);
      chk("dw", dw, 16'h5678);
      $display("latency test done");
   endtask
   // swap lanes 0 and 1, invert logical lane 1
   task automatic t_xbar();
      wr(ADDR_XBAR_BASE, 8'h01);
      wr(ADDR_POLARITY, 8'h02);
      @(posedge clk);
      #1 p = phys;
      @(posedge clk);
      #1 chk("lanes", logic_out[15:0], {~p[7:0], p[15:8]});
      $display("crossbar test done");
   endtask
   task automatic t_link();
      wr(ADDR_LINK_CTRL, 8'h4B);
      #1 chk("dual", 16'({two, link_en}), 16'h0007);
      chk("sum select", 16'(sum), 16'h0001);
      wr(ADDR_LINK_CTRL, 8'h07);
      #1 chk("single", 16'(link_en), 16'h0001);
      chk("page", 16'(page), 16'h0001);
      $display("link test done");
   endtask
   initial begin
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_sync();
      t_lat();
      t_xbar();
      t_link();
      finish_test();
   end
   // watchdog far beyond the 66 cycles the tests need
   initial begin
      #100000;
      fail_count++;
      finish_test();
   end
endmodule
